/* pcrs_core.v */
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "pcrs_regs.vh"
module pcrs_core #(
  parameter MEM_BYTES = 21'h002000   // implemented program memory size
) (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,       // asynchronous power-on reset
  input  wire        soft_resetn,   // other device resets, synchronous
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // sequencer commands, one-cycle pulses
  input  wire        seq_advance,   // sequential fetch
  input  wire        seq_jump,      // goto, branch, call target
  input  wire [20:0] seq_target,
  input  wire        seq_call,      // call or relative_call_instr push
  input  wire        seq_irq_high,  // acknowledged high interrupt
  input  wire        seq_irq_low,   // acknowledged low interrupt
  input  wire        seq_return,    // return, return_with_literal_instr,
                                    // return_from_interrupt_instr
  input  wire        seq_push,      // explicit push instruction
  input  wire        seq_pop,       // explicit pop instruction
  // program memory fetch
  output reg  [20:0] fetch_addr,    // pc, bit 0 always zero
  input  wire [15:0] mem_rdata,
  output wire [15:0] fetch_data,    // zero outside memory
  // device reset request
  output reg         overflow_reset // one-cycle pulse
);

  // ****************************************************
  // state
  // ****************************************************
  reg [20:0] stack_mem [1:31];           // entry 0 has no storage
  reg [4:0]  return_stack_pointer;
  reg        stack_full_flag;
  reg        stack_underflow_flag;
  reg [7:0]  pc_high_holding_latch;
  reg [4:0]  pc_upper_holding_latch;
  reg        overflow_reset_enable;
  reg        ap_valid;                   // data phase pending
  reg        ap_write;
  reg [7:0]  ap_addr;
  wire [20:0] pc = fetch_addr;
  wire [20:0] top_entry = (return_stack_pointer == `PCRS_SP_EMPTY) ?
                          `PCRS_PC_RESET :
                          stack_mem[return_stack_pointer];
  wire [7:0]  pc_low_byte   = pc[7:0];
  wire [7:0]  pc_high_byte  = pc[15:8];
  wire [4:0]  pc_upper_byte = pc[20:16];

  // beyond memory returns nop
  assign fetch_data = (fetch_addr < MEM_BYTES) ? mem_rdata : 16'h0000;
  assign hreadyout  = 1'b1;              // zero wait states
  assign hresp      = 1'b0;              // always okay

  // ****************************************************
  // bus address phase capture
  // ****************************************************
  wire take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else begin
      ap_valid <= take;
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  wire wr = ap_valid & ap_write;
  wire rd_now = take & ~hwrite;          // read in address phase
  wire wr_pcl  = wr & (ap_addr == `PCRS_OFS_PCL);
  wire wr_sp   = wr & (ap_addr == `PCRS_OFS_SP);
  wire wr_top_entry_low = wr & (ap_addr == `PCRS_OFS_TOP_ENTRY_LOW);
  wire wr_top_entry_high = wr & (ap_addr == `PCRS_OFS_TOP_ENTRY_HIGH);
  wire wr_top_entry_upper = wr & (ap_addr == `PCRS_OFS_TOP_ENTRY_UPPER);
  wire rd_pcl  = rd_now & (haddr == `PCRS_OFS_PCL);

  // ****************************************************
  // read data, registered
  // ****************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_now) begin
      case (haddr)
        `PCRS_OFS_PCL:    hrdata <= {24'h000000, pc_low_byte};
        `PCRS_OFS_PC_HIGH_HOLDING_LATCH: hrdata <= {24'h000000, pc_high_holding_latch};
        `PCRS_OFS_PC_UPPER_HOLDING_LATCH: hrdata <= {27'h0000000, pc_upper_holding_latch};
        `PCRS_OFS_SP:     hrdata <= {24'h000000, stack_full_flag,
                            stack_underflow_flag, 1'b0,
                            return_stack_pointer};
        `PCRS_OFS_TOP_ENTRY_LOW:   hrdata <= {24'h000000, top_entry[7:0]};
        `PCRS_OFS_TOP_ENTRY_HIGH:   hrdata <= {24'h000000, top_entry[15:8]};
        `PCRS_OFS_TOP_ENTRY_UPPER:   hrdata <= {27'h0000000, top_entry[20:16]};
        `PCRS_OFS_CFG:    hrdata <= {31'h00000000, overflow_reset_enable};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // stack and pc sequencing
  // ****************************************************
  wire do_push = seq_call | seq_irq_high | seq_irq_low | seq_push;
  wire full_push = do_push & (return_stack_pointer == `PCRS_SP_TOP - 5'h01);
  wire [20:0] ret_addr = seq_push ? pc : pc + `PCRS_PC_STEP;
  wire [4:0]  sp_inc = return_stack_pointer + `PCRS_SP_ONE;
  wire [4:0]  sp_dec = return_stack_pointer - `PCRS_SP_ONE;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_addr             <= `PCRS_PC_RESET;
      return_stack_pointer   <= `PCRS_SP_EMPTY;
      stack_full_flag        <= 1'b0;
      stack_underflow_flag   <= 1'b0;
      pc_high_holding_latch  <= 8'h00;
      pc_upper_holding_latch <= 5'h00;
      overflow_reset_enable  <= `PCRS_CFG_RESET;
      overflow_reset         <= 1'b0;
    end else if (!soft_resetn) begin
      // device reset: flags survive, pointer and pc clear
      fetch_addr             <= `PCRS_PC_RESET;
      return_stack_pointer   <= `PCRS_SP_EMPTY;
      overflow_reset         <= 1'b0;
    end else begin
      overflow_reset <= 1'b0;
      // latch upper pc bytes on low byte read
      if (rd_pcl) begin
        pc_high_holding_latch  <= pc_high_byte;
        pc_upper_holding_latch <= pc_upper_byte;
      end
      if (wr & (ap_addr == `PCRS_OFS_PC_HIGH_HOLDING_LATCH))
        pc_high_holding_latch <= hwdata[7:0];
      if (wr & (ap_addr == `PCRS_OFS_PC_UPPER_HOLDING_LATCH))
        pc_upper_holding_latch <= hwdata[4:0];
      if (wr & (ap_addr == `PCRS_OFS_CFG))
        overflow_reset_enable <= hwdata[0];
      // program counter
      if (wr_pcl) begin
        fetch_addr <= {pc_upper_holding_latch, pc_high_holding_latch,
                       hwdata[7:1], 1'b0};
      end else if (seq_irq_high) begin
        fetch_addr <= `PCRS_VEC_HIGH;
      end else if (seq_irq_low) begin
        fetch_addr <= `PCRS_VEC_LOW;
      end else if (seq_jump) begin
        fetch_addr <= {seq_target[20:1], 1'b0};
      end else if (seq_return) begin
        fetch_addr <= {top_entry[20:1], 1'b0};
      end else if (seq_advance) begin
        fetch_addr <= pc + `PCRS_PC_STEP;
      end
      // stack pointer and flags
      if (do_push) begin
        if (return_stack_pointer != `PCRS_SP_TOP) begin
          stack_mem[sp_inc] <= ret_addr;
          return_stack_pointer <= sp_inc;
          if (full_push) begin
            stack_full_flag <= 1'b1;
            if (overflow_reset_enable)
              overflow_reset <= 1'b1;
          end
        end
      end else if (seq_return | seq_pop) begin
        if (return_stack_pointer == `PCRS_SP_EMPTY)
          stack_underflow_flag <= 1'b1;
        else
          return_stack_pointer <= sp_dec;
      end else if (wr_sp) begin
        return_stack_pointer <= hwdata[4:0];
      end
      // flag clears; a set in the same cycle wins
      if (wr_sp && !hwdata[`PCRS_SP_FULL_BIT] && !full_push)
        stack_full_flag <= 1'b0;
      if (wr_sp && !hwdata[`PCRS_SP_UNF_BIT] &&
          !((seq_return | seq_pop) &&
            return_stack_pointer == `PCRS_SP_EMPTY))
        stack_underflow_flag <= 1'b0;
      // top entry writes
      if (return_stack_pointer != `PCRS_SP_EMPTY && !do_push) begin
        if (wr_top_entry_low)
          stack_mem[return_stack_pointer][7:0] <= hwdata[7:0];
        if (wr_top_entry_high)
          stack_mem[return_stack_pointer][15:8] <= hwdata[7:0];
        if (wr_top_entry_upper)
          stack_mem[return_stack_pointer][20:16] <= hwdata[4:0];
      end
    end
  end

  // overflow reset pulse is looped back by the reset controller as
  // soft_resetn; the pointer then clears while the full flag stays
endmodule
`default_nettype wire

/* pcrs_core_props.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcrs_regs.vh"
// ****
// checker on the core ports
// ****
module pcrs_core_props #(
  parameter MEM_BYTES = 21'h002000
) (
  input wire logic        hclk, hresetn, soft_resetn,
  input wire logic        hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] hwdata,
  input wire logic        seq_advance, seq_jump, seq_irq_high,
  input wire logic        seq_irq_low, seq_return,
  input wire logic [20:0] seq_target, fetch_addr,
  input wire logic [15:0] fetch_data,
  input wire logic        overflow_reset
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic pcl_wr;  // pc low byte write now in its data phase
  wire  quiet = soft_resetn && !pcl_wr;  // nothing outranks the sequencer
  wire  lone  = quiet && !seq_jump && !seq_irq_high && !seq_irq_low;
  // remember a taken pc low byte write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) pcl_wr <= 1'b0;
    else pcl_wr <= hsel && hready && htrans[1] && hwrite
                   && haddr == `PCRS_OFS_PCL;
  // address phase of a pc low byte write
  sequence s_pcl_addr;
    hsel && hready && htrans[1] && hwrite && haddr == `PCRS_OFS_PCL;
  endsequence
  a_pc_even: assert property (fetch_addr[0] == 1'b0)
    else $error("pc bit 0 set");
  a_step_two: assert property (seq_advance && lone && !seq_return |=>
    fetch_addr == $past(fetch_addr) + 21'h2) else $error("bad pc step");
  a_vec_high: assert property (seq_irq_high && quiet |=>
    fetch_addr == `PCRS_VEC_HIGH) else $error("bad high vector");
  a_vec_low: assert property (seq_irq_low && !seq_irq_high && quiet |=>
    fetch_addr == `PCRS_VEC_LOW) else $error("bad low vector");
  a_jump_load: assert property (seq_jump && lone || seq_jump && quiet
    && !seq_irq_high && !seq_irq_low |=>
    fetch_addr == {$past(seq_target[20:1]), 1'b0}) else $error("bad jump");
  a_pcl_load: assert property (s_pcl_addr ##1 soft_resetn |=>
    fetch_addr[7:0] == {$past(hwdata[7:1]), 1'b0}) else $error("bad pcl");
  a_fetch_zero: assert property (fetch_addr >= MEM_BYTES |->
    fetch_data == 16'h0000) else $error("fetch beyond memory not zero");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_ovf_pulse: assert property (overflow_reset |=> !overflow_reset)
    else $error("overflow request longer than one cycle");
  a_soft_zero: assert property (!soft_resetn |=>
    fetch_addr == `PCRS_PC_RESET) else $error("pc not cleared by reset");
endmodule
bind pcrs_core pcrs_core_props #(.MEM_BYTES(MEM_BYTES)) u_props (.*);
`default_nettype wire

/* pcrs_pmem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// program memory model on the fetch port
// ****
module pcrs_pmem_model (
  // fetch port
  input  wire logic [20:0] fetch_addr,
  output logic      [15:0] mem_rdata
);
  // each word is a fold of its own address, so a stale fetch shows
  // the bench keeps stack accesses apart from sequencer pulses
  assign mem_rdata = fetch_addr[16:1] ^ 16'h5a3c;
endmodule
`default_nettype wire

/* pcrs_regs.vh */
`ifndef PCRS_REGS_VH
`define PCRS_REGS_VH
// ****************************************************
// register byte addresses on the ahb-lite bus
// ****************************************************
`define PCRS_OFS_PCL      8'h00
`define PCRS_OFS_PC_HIGH_HOLDING_LATCH   8'h04
`define PCRS_OFS_PC_UPPER_HOLDING_LATCH   8'h08
`define PCRS_OFS_SP       8'h0c
`define PCRS_OFS_TOP_ENTRY_LOW     8'h10
`define PCRS_OFS_TOP_ENTRY_HIGH     8'h14
`define PCRS_OFS_TOP_ENTRY_UPPER     8'h18
`define PCRS_OFS_CFG      8'h1c
// ****************************************************
// field positions and constants
// ****************************************************
`define PCRS_SP_FULL_BIT  7
`define PCRS_SP_UNF_BIT   6
`define PCRS_PC_RESET     21'h000000
`define PCRS_VEC_HIGH     21'h000008
`define PCRS_VEC_LOW      21'h000018
`define PCRS_PC_STEP      21'h000002
`define PCRS_SP_EMPTY     5'h00
`define PCRS_SP_TOP       5'h1f
`define PCRS_SP_ONE       5'h01
`define PCRS_CFG_RESET    1'b1
`define PCRS_HTRANS_NSEQ  1'b1
`endif

/* program_counter_return_stack_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pcrs_regs.vh"
module program_counter_return_stack_tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, soft_resetn = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
  logic [7:0]  haddr = 8'h00, sq = 8'h00;  // sequencer pulses
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, exp_q[$];
  logic [20:0] tgt = 21'h0, fetch_addr, a;
  logic [15:0] mem_rdata, fetch_data;
  wire         hreadyout, hresp, overflow_reset;
  integer      seed = 32'h8075, failures = 0, num_checks = 0;
  integer      cyc = 0, ovf = 0, i;
  string       nm_q[$];
  always #2 hclk = ~hclk;
  pcrs_core #(.MEM_BYTES(21'h002000)) u_dut (.hclk(hclk), .hresetn(hresetn),
    .soft_resetn(soft_resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .seq_advance(sq[7]), .seq_jump(sq[6]), .seq_call(sq[5]),
    .seq_irq_high(sq[4]), .seq_irq_low(sq[3]), .seq_return(sq[2]),
    .seq_push(sq[1]), .seq_pop(sq[0]), .seq_target(tgt),
    .fetch_addr(fetch_addr), .mem_rdata(mem_rdata),
    .fetch_data(fetch_data), .overflow_reset(overflow_reset));
  pcrs_pmem_model u_mem (.fetch_addr(fetch_addr), .mem_rdata(mem_rdata));
  task chk(input string n, input logic [31:0] x, input logic [31:0] s);
    num_checks++;
    if (s !== x) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // one single ahb-lite word transfer
  task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= ad; hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_ph <= !w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [31:0] x, input string n);
    exp_q.push_back(x);
    nm_q.push_back(n);
    bus(1'b0, ad, 32'h0);
  endtask
  task rd_pc(input logic [20:0] p);
    rd(`PCRS_OFS_PCL, {24'h0, p[7:0]}, "pc_low_byte");
    rd(`PCRS_OFS_PC_HIGH_HOLDING_LATCH, {24'h0, p[15:8]}, "pc_high_holding_latch");
    rd(`PCRS_OFS_PC_UPPER_HOLDING_LATCH, {27'h0, p[20:16]}, "pc_upper_holding_latch");
  endtask
  // one-cycle sequencer pulse
  task op(input logic [7:0] s, input logic [20:0] t);
    @(posedge hclk);
    sq <= s; tgt <= t;
    @(posedge hclk);
    sq <= 8'h00;
  endtask
  task soft_rst;
    @(posedge hclk) soft_resetn <= 1'b0;
    @(posedge hclk) soft_resetn <= 1'b1;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // monitor: read data against the oldest note, overflow pulses, timeout
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) chk(nm_q.pop_front(), exp_q.pop_front(), hrdata);
    if (overflow_reset === 1'b1) ovf++;
    cyc++;
    if (cyc == 20000) begin failures++; tally_and_finish(); end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PCRS_OFS_SP, 32'h0, "return_stack_pointer");
    rd(`PCRS_OFS_CFG, 32'h1, "overflow_reset_enable");
    rd(8'h20, 32'h0, "unmapped");
    rd_pc(`PCRS_PC_RESET);
    a = 21'($random(seed));
    op(8'h40, a);
    op(8'h80, 21'h0);
    a[0] = 1'b0;
    rd_pc(a + 21'h2);
    bus(1'b1, `PCRS_OFS_PC_HIGH_HOLDING_LATCH, 32'h12);
    bus(1'b1, `PCRS_OFS_PC_UPPER_HOLDING_LATCH, 32'h03);
    bus(1'b1, `PCRS_OFS_PCL, 32'h35);
    rd_pc(21'h031234);
    chk("fetch_data", 32'h0, {16'h0, fetch_data});
    $display("test pc done");
    op(8'h60, 21'h000400);
    rd(`PCRS_OFS_SP, 32'h01, "return_stack_pointer");
    rd(`PCRS_OFS_TOP_ENTRY_LOW, 32'h36, "top_entry_low");
    rd(`PCRS_OFS_TOP_ENTRY_HIGH, 32'h12, "top_entry_high");
    rd(`PCRS_OFS_TOP_ENTRY_UPPER, 32'h03, "top_entry_upper");
    op(8'h04, 21'h0);
    rd_pc(21'h031236);
    op(8'h04, 21'h0);
    rd(`PCRS_OFS_SP, 32'h40, "return_stack_pointer");
    rd(`PCRS_OFS_PC_HIGH_HOLDING_LATCH, 32'h12, "pc_high_holding_latch");
    rd_pc(21'h0);
    chk("fetch_data", 32'h5a3c, {16'h0, fetch_data});
    bus(1'b1, `PCRS_OFS_SP, 32'h00);
    rd(`PCRS_OFS_SP, 32'h00, "return_stack_pointer");
    op(8'h10, 21'h0);
    rd_pc(`PCRS_VEC_HIGH);
    op(8'h08, 21'h0);
    rd_pc(`PCRS_VEC_LOW);
    rd(`PCRS_OFS_TOP_ENTRY_LOW, 32'h0a, "top_entry_low");
    $display("test call and return done");
    soft_rst();
    rd(`PCRS_OFS_SP, 32'h00, "return_stack_pointer");
    for (i = 0; i < 31; i++) op(8'h02, 21'h0);
    rd(`PCRS_OFS_SP, 32'h9f, "return_stack_pointer");
    chk("overflow_reset", 32'h1, ovf);
    soft_rst();
    rd(`PCRS_OFS_SP, 32'h80, "return_stack_pointer");
    bus(1'b1, `PCRS_OFS_CFG, 32'h0);
    bus(1'b1, `PCRS_OFS_SP, 32'h0);
    for (i = 0; i < 32; i++) op(8'h02, 21'h0);
    rd(`PCRS_OFS_SP, 32'h9f, "return_stack_pointer");
    chk("overflow_reset", 32'h1, ovf);
    bus(1'b1, `PCRS_OFS_SP, 32'h85);
    op(8'h01, 21'h0);
    rd(`PCRS_OFS_SP, 32'h84, "return_stack_pointer");
    bus(1'b1, `PCRS_OFS_SP, 32'h04);
    rd(`PCRS_OFS_SP, 32'h04, "return_stack_pointer");
    $display("test stack limits done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
